// file: hdl/sptr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sptr_map.svh"

// Contract
// - Defaults reset, then sideband or memory overrides
// - Upstream-only fields use upstream copy switchwide
// - Bit6 writable, disables relaxed ordering, memory-only load
// - Bit10 disables the port, resets zero
// - Bits9:8 set rate change attempt count
// - Bit11 resets one upstream, zero downstream
// - Bit16 disables PHY error retrain, byte 79h
// - Opmode bit23 master clock off, strap reset
// - Bits22:16 enable pairs, 7Fh or 5Fh
// - Opmode low bits report straps, reset 00A2h
// - PHY3 bits6:0 per-lane mode, reset zero
// - PHY3 bits31:15 global delta from upstream
// - PHY4 low half margin, 116Bh, upstream
module sptr_regs (
   input wire logic clk,
   input wire logic resetn,
   // Port identity and straps
   input wire logic is_upstream,
   input wire logic six_port_mode,
   input wire logic clock_buffer_powerdown_strap,
   // Upstream port copies of the shared registers
   input wire logic [31:0] up_transaction_layer_tuning,
   input wire logic [31:0] up_phy_lane_and_delta_params,
   input wire logic [31:0] up_phy_tx_margin_params,
   input wire logic [31:0] up_operation_mode_and_clock_buffers,
   // Configuration access
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   // Default loads from sideband or configuration memory
   input wire logic ovr_valid,
   input wire logic ovr_from_rom,
   input wire logic [7:0] ovr_addr,
   input wire logic [31:0] ovr_data,
   // Controls fed to the port logic
   output logic relaxed_order_off,
   output logic [1:0] rate_change_attempt_count,
   output logic port_disable,
   output logic reset_select,
   output logic [7:0] phy_misc_byte,
   output logic retrain_disable,
   output logic [6:0] lane_mode,
   output logic [16:0] phy_delta,
   output logic [15:0] tx_margin,
   output logic refclk_master_off,
   output logic [6:0] reference_clock_out_pairs,
   output logic [8:0] op_mode_straps
);

   // ============================================================
   // Decoding helpers
   // Both are pure lookups; mask_of also feeds parameter values

   // Address to slot; bit 2 marks a hit
   // One decoder serves both the access and the load path
   function automatic logic [2:0] slot_of(input logic [7:0] addr);
      case (addr)
         `SPTR_OFS_TL: slot_of = {1'b1, sptr_pkg::SPTR_TL};
         `SPTR_OFS_PHY3: slot_of = {1'b1, sptr_pkg::SPTR_PHY3};
         `SPTR_OFS_PHY4: slot_of = {1'b1, sptr_pkg::SPTR_PHY4};
         `SPTR_OFS_OPMODE: slot_of = {1'b1, sptr_pkg::SPTR_OPMODE};
         default: slot_of = 3'h0;
      endcase
   endfunction

   // Mask table per slot and kind
   function automatic logic [31:0] mask_of(input int slot,
                                           input sptr_pkg::sptr_mask_t kind);
      logic [31:0] m;
      m = 32'h0000_0000;
      case (kind)
         // Bits that exist at all
         sptr_pkg::SPTR_M_DEF: begin
            case (slot)
               0: m = `SPTR_DEF_TL;
               1: m = `SPTR_DEF_PHY3;
               2: m = `SPTR_DEF_PHY4;
               default: m = `SPTR_DEF_OPMODE;
            endcase
         end
         // Only the two writable tuning bits
         sptr_pkg::SPTR_M_SW: begin
            m = (slot == 0) ? `SPTR_SW_TL : `SPTR_SW_NONE;
         end
         // Sideband reach, ordering bit held back
         sptr_pkg::SPTR_M_SB: begin
            case (slot)
               0: m = `SPTR_SB_TL;
               1: m = `SPTR_DEF_PHY3;
               2: m = `SPTR_DEF_PHY4;
               default: m = `SPTR_SB_OPMODE;
            endcase
         end
         // Memory reach, ordering bit included
         sptr_pkg::SPTR_M_ROM: begin
            case (slot)
               0: m = `SPTR_ROM_TL;
               1: m = `SPTR_DEF_PHY3;
               2: m = `SPTR_DEF_PHY4;
               default: m = `SPTR_ROM_OPMODE;
            endcase
         end
         // Switchwide fields taken from the upstream copy
         sptr_pkg::SPTR_M_UP: begin
            case (slot)
               0: m = `SPTR_UP_TL;
               1: m = `SPTR_UP_PHY3;
               2: m = `SPTR_UP_PHY4;
               default: m = `SPTR_UP_OPMODE;
            endcase
         end
         default: m = 32'h0000_0000;
      endcase
      // Unknown kinds give no bits at all
      return m;
   endfunction

   // ============================================================
   // Reset values, some steered by port role and straps
   // Per-slot words, indexed by slot number
   logic [31:0] rst_val [4];
   logic [31:0] local_word [4];
   logic [31:0] up_word [4];
   logic [31:0] eff_word [4];
   logic [2:0] cfg_slot;
   logic [2:0] ovr_slot;
   logic [6:0] pairs_rst;

   // Reset words per slot; low mode bits are fixed straps
   always_comb begin
      pairs_rst = six_port_mode ? `SPTR_RST_PAIRS_SIX
                                : `SPTR_RST_PAIRS_SMALL;
      rst_val[0] = `SPTR_RST_TL |
                   (is_upstream ? `SPTR_RST_TL_UPBIT : 32'h0000_0000);
      rst_val[1] = `SPTR_RST_PHY3;
      rst_val[2] = `SPTR_RST_PHY4;
      // Strap is sampled while reset is held, a synchronous capture
      rst_val[3] = {8'h00, clock_buffer_powerdown_strap, pairs_rst,
                    `SPTR_RST_OPMODE_LO};
   end

   // Upstream copies, gathered for the loop
   // Only read on downstream ports, in the shared fields
   always_comb begin
      up_word[0] = up_transaction_layer_tuning;
      up_word[1] = up_phy_lane_and_delta_params;
      up_word[2] = up_phy_tx_margin_params;
      up_word[3] = up_operation_mode_and_clock_buffers;
   end

   // Slot lookups for the access and the load
   assign cfg_slot = slot_of(cfg_addr);
   assign ovr_slot = slot_of(ovr_addr);

   // ============================================================
   // One storage word per register
   // A load and a write may meet in one cycle; the load wins
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_word
         sptr_reg_word #(
            .DEF_MASK(mask_of(gi, sptr_pkg::SPTR_M_DEF)),
            .SW_MASK(mask_of(gi, sptr_pkg::SPTR_M_SW)),
            .SB_MASK(mask_of(gi, sptr_pkg::SPTR_M_SB)),
            .ROM_MASK(mask_of(gi, sptr_pkg::SPTR_M_ROM))
         ) u_word (
            .clk(clk),
            .resetn(resetn),
            .rst_val(rst_val[gi]),
            .sw_we(cfg_req && cfg_we && cfg_slot[2] &&
                   (cfg_slot[1:0] == 2'(gi))),
            .sw_be(cfg_be),
            .sw_data(cfg_wdata),
            .ovr_we(ovr_valid && ovr_slot[2] &&
                    (ovr_slot[1:0] == 2'(gi))),
            .ovr_from_rom(ovr_from_rom),
            .ovr_data(ovr_data),
            .value(local_word[gi])
         );

         // Downstream ports see the switchwide copy in shared fields;
         // keeps all ports agreeing without a second write path
         always_comb begin
            if (is_upstream) begin
               eff_word[gi] = local_word[gi];
            end else begin
               eff_word[gi] =
                  (local_word[gi] & ~mask_of(gi, sptr_pkg::SPTR_M_UP)) |
                  (up_word[gi] & mask_of(gi, sptr_pkg::SPTR_M_UP) &
                   mask_of(gi, sptr_pkg::SPTR_M_DEF));
            end
         end
      end
   endgenerate

   // ============================================================
   // Configuration read answer, one cycle after the request
   logic next_cfg_ack;
   logic [31:0] next_cfg_rdata;

   always_comb begin
      next_cfg_ack = cfg_req;
      // Read data holds between answers
      next_cfg_rdata = cfg_rdata;
      if (cfg_req) begin
         // Unmapped offsets and writes answer zero
         next_cfg_rdata = 32'h0000_0000;
         if (!cfg_we && cfg_slot[2]) begin
            next_cfg_rdata = eff_word[cfg_slot[1:0]];
         end
      end
   end

   // Ack and data land together; no wait states
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_ack <= 1'b0;
         cfg_rdata <= 32'h0000_0000;
      end else begin
         cfg_ack <= next_cfg_ack;
         cfg_rdata <= next_cfg_rdata;
      end
   end

   // ============================================================
   // Field outputs, registered so the port logic sees clean levels
   // Next values for the registered field outputs
   logic next_relaxed_order_off;
   logic [1:0] next_rate_change_attempt_count;
   logic next_port_disable;
   logic next_reset_select;
   logic [7:0] next_phy_misc_byte;
   logic next_retrain_disable;
   logic [6:0] next_lane_mode;
   logic [16:0] next_phy_delta;
   logic [15:0] next_tx_margin;
   logic next_refclk_master_off;
   logic [6:0] next_pairs;
   logic [8:0] next_op_mode_straps;

   always_comb begin
      // Tuning register fields
      next_relaxed_order_off = eff_word[0][`SPTR_TL_RELAX_OFF];
      next_rate_change_attempt_count =
         eff_word[0][`SPTR_TL_RATE_HI:`SPTR_TL_RATE_LO];
      next_port_disable = eff_word[0][`SPTR_TL_PORT_DIS];
      // Only meaningful upstream; downstream reports zero
      next_reset_select = eff_word[0][`SPTR_TL_RST_SEL] & is_upstream;
      next_phy_misc_byte =
         eff_word[0][`SPTR_TL_RETRAIN_DIS+7:`SPTR_TL_RETRAIN_DIS];
      next_retrain_disable = eff_word[0][`SPTR_TL_RETRAIN_DIS];
      // Phy parameter fields
      next_lane_mode = eff_word[1][`SPTR_PHY3_LANE_HI:0];
      next_phy_delta = eff_word[1][31:`SPTR_PHY3_DELTA_LO];
      next_tx_margin = eff_word[2][`SPTR_PHY4_MARGIN_HI:0];
      // Clock buffer and strap fields
      next_refclk_master_off = eff_word[3][`SPTR_OPM_CLK_OFF];
      next_pairs = eff_word[3][`SPTR_OPM_PAIRS_HI:`SPTR_OPM_PAIRS_LO];
      next_op_mode_straps = eff_word[3][`SPTR_OPM_MODE_HI:0];
   end

   // Fields clear in reset; defaults show one edge after release
   always_ff @(posedge clk) begin
      if (!resetn) begin
         relaxed_order_off <= 1'b0;
         rate_change_attempt_count <= 2'h0;
         port_disable <= 1'b0;
         reset_select <= 1'b0;
         phy_misc_byte <= 8'h00;
         retrain_disable <= 1'b0;
         lane_mode <= 7'h00;
         phy_delta <= 17'h0_0000;
         tx_margin <= 16'h0000;
         refclk_master_off <= 1'b0;
         reference_clock_out_pairs <= 7'h00;
         op_mode_straps <= 9'h000;
      end else begin
         relaxed_order_off <= next_relaxed_order_off;
         rate_change_attempt_count <= next_rate_change_attempt_count;
         port_disable <= next_port_disable;
         reset_select <= next_reset_select;
         phy_misc_byte <= next_phy_misc_byte;
         retrain_disable <= next_retrain_disable;
         lane_mode <= next_lane_mode;
         phy_delta <= next_phy_delta;
         tx_margin <= next_tx_margin;
         refclk_master_off <= next_refclk_master_off;
         reference_clock_out_pairs <= next_pairs;
         op_mode_straps <= next_op_mode_straps;
      end
   end

endmodule // sptr_regs
`default_nettype wire

// file: hdl/sptr_map.svh
`ifndef SPTR_MAP_SVH
`define SPTR_MAP_SVH

// ============================================================
// Register byte offsets
`define SPTR_OFS_TL 8'h8C
`define SPTR_OFS_PHY3 8'h90
`define SPTR_OFS_PHY4 8'h94
`define SPTR_OFS_OPMODE 8'h98

// ============================================================
// Bits that exist (everything else is reserved, reads zero)
`define SPTR_DEF_TL 32'hBFFF_1FFF
`define SPTR_DEF_PHY3 32'hFFFF_807F
`define SPTR_DEF_PHY4 32'h0000_FFFF
`define SPTR_DEF_OPMODE 32'h0FFF_01FF

// ============================================================
// Bits that configuration software may write
`define SPTR_SW_TL 32'h0000_0060
`define SPTR_SW_NONE 32'h0000_0000

// ============================================================
// Bits the SMBus/I2C sideband may load (relaxed-order bit excluded)
`define SPTR_SB_TL 32'hBFFF_1FBF
`define SPTR_SB_OPMODE 32'h0FFF_0000
// Bits the serial configuration memory may load
`define SPTR_ROM_TL 32'hBFFF_1FFF
`define SPTR_ROM_OPMODE 32'h0FFF_0000

// ============================================================
// Bits held once for the whole switch, taken from the upstream port
`define SPTR_UP_TL 32'h3C00_10EF
`define SPTR_UP_PHY3 32'hFFFF_8000
`define SPTR_UP_PHY4 32'h0000_FFFF
`define SPTR_UP_OPMODE 32'h00FF_0000

// ============================================================
// Reset values
`define SPTR_RST_TL 32'h0079_1094
`define SPTR_RST_TL_UPBIT 32'h0000_0800
`define SPTR_RST_PHY3 32'h0000_8000
`define SPTR_RST_PHY4 32'h0000_116B
`define SPTR_RST_OPMODE_LO 16'h00A2
`define SPTR_RST_PAIRS_SIX 7'h7F
`define SPTR_RST_PAIRS_SMALL 7'h5F

// ============================================================
// Field positions
`define SPTR_TL_RELAX_OFF 6
`define SPTR_TL_RATE_LO 8
`define SPTR_TL_RATE_HI 9
`define SPTR_TL_PORT_DIS 10
`define SPTR_TL_RST_SEL 11
`define SPTR_TL_RETRAIN_DIS 16
`define SPTR_PHY3_LANE_HI 6
`define SPTR_PHY3_DELTA_LO 15
`define SPTR_PHY4_MARGIN_HI 15
`define SPTR_OPM_MODE_HI 8
`define SPTR_OPM_PAIRS_LO 16
`define SPTR_OPM_PAIRS_HI 22
`define SPTR_OPM_CLK_OFF 23

`endif

// file: hdl/sptr_pkg.sv
package sptr_pkg;

   // Register slots, in address order
   typedef enum logic [1:0] {
      SPTR_TL,
      SPTR_PHY3,
      SPTR_PHY4,
      SPTR_OPMODE
   } sptr_slot_t;

   // Which mask a lookup asks for
   typedef enum logic [2:0] {
      SPTR_M_DEF,
      SPTR_M_SW,
      SPTR_M_SB,
      SPTR_M_ROM,
      SPTR_M_UP
   } sptr_mask_t;

   typedef logic [31:0] sptr_word_t;

endpackage

// file: hdl/sptr_reg_word.sv
`timescale 1ns/1ps
`default_nettype none
`include "sptr_map.svh"

module sptr_reg_word #(
   parameter logic [31:0] DEF_MASK = 32'h0000_0000,
   parameter logic [31:0] SW_MASK = 32'h0000_0000,
   parameter logic [31:0] SB_MASK = 32'h0000_0000,
   parameter logic [31:0] ROM_MASK = 32'h0000_0000
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [31:0] rst_val,
   input wire logic sw_we,
   input wire logic [3:0] sw_be,
   input wire logic [31:0] sw_data,
   input wire logic ovr_we,
   input wire logic ovr_from_rom,
   input wire logic [31:0] ovr_data,
   output logic [31:0] value
);

   logic [31:0] next_value;
   logic [31:0] be_mask;
   logic [31:0] ovr_mask;

   // ============================================================
   // Next value: software write first, loaded default on top
   always_comb begin
      be_mask = {{8{sw_be[3]}}, {8{sw_be[2]}}, {8{sw_be[1]}}, {8{sw_be[0]}}};
      ovr_mask = ovr_from_rom ? ROM_MASK : SB_MASK;
      next_value = value;
      if (sw_we) begin
         // Only writable bits move; reserved bits stay put
         next_value = (value & ~(SW_MASK & be_mask)) |
                      (sw_data & SW_MASK & be_mask);
      end
      if (ovr_we) begin
         // Sideband or memory load replaces the default
         next_value = (next_value & ~ovr_mask) | (ovr_data & ovr_mask);
      end
      next_value = next_value & DEF_MASK;
   end

   // Reset to the documented default for this port
   always_ff @(posedge clk) begin
      if (!resetn) begin
         value <= rst_val & DEF_MASK;
      end else begin
         value <= next_value;
      end
   end

endmodule // sptr_reg_word
`default_nettype wire

// file: sim/sptr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks for the tuning register bank
module sptr_regs_asserts (
   input wire logic clk,
   input wire logic resetn,
   input wire logic is_upstream,
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   input wire logic ovr_valid,
   input wire logic [31:0] ovr_data,
   input wire logic [7:0] ovr_addr,
   input wire logic relaxed_order_off,
   input wire logic [1:0] rate_change_attempt_count,
   input wire logic port_disable,
   input wire logic reset_select,
   input wire logic [7:0] phy_misc_byte,
   input wire logic retrain_disable,
   input wire logic [15:0] tx_margin,
   input wire logic refclk_master_off,
   input wire logic [6:0] reference_clock_out_pairs,
   input wire logic [8:0] op_mode_straps
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Plain upstream read, no load racing it
   wire rd_up = cfg_req && !cfg_we && is_upstream && !ovr_valid;

   a_ack_next: assert property (cfg_req |=> cfg_ack)
      else $error("ack missing after request");
   a_ack_cause: assert property (cfg_ack |-> $past(cfg_req))
      else $error("ack without request");
   a_unmapped_zero: assert property (cfg_req && !cfg_we &&
      !(cfg_addr inside {8'h8C, 8'h90, 8'h94, 8'h98}) |=> cfg_rdata == '0)
      else $error("unmapped read not zero");
   a_down_rstsel: assert property (!is_upstream |-> !reset_select)
      else $error("reset select set on downstream port");
   a_retrain_bit: assert property (retrain_disable == phy_misc_byte[0])
      else $error("retrain control differs from byte bit 0");
   a_tl_fields: assert property (rd_up && cfg_addr == 8'h8C |=>
      cfg_rdata[23:16] == phy_misc_byte && cfg_rdata[15:13] == 3'h0 &&
      cfg_rdata[11:8] == {reset_select, port_disable,
      rate_change_attempt_count} && cfg_rdata[6] == relaxed_order_off)
      else $error("tuning read disagrees with controls");
   a_margin_read: assert property (rd_up && cfg_addr == 8'h94 |=>
      cfg_rdata == {16'h0000, tx_margin})
      else $error("margin read disagrees");
   a_opmode_read: assert property (rd_up && cfg_addr == 8'h98 |=>
      cfg_rdata[31:28] == 4'h0 && cfg_rdata[15:9] == 7'h00 &&
      cfg_rdata[23:16] == {refclk_master_off, reference_clock_out_pairs} &&
      cfg_rdata[8:0] == op_mode_straps)
      else $error("mode read disagrees");
   a_ovr_lands: assert property (ovr_valid && ovr_addr == 8'h94 &&
      is_upstream ##1 !ovr_valid |=>
      {16'h0000, tx_margin} == ($past(ovr_data, 2) & 32'h0000_FFFF))
      else $error("loaded margin not applied");
   a_relax_write: assert property (cfg_req && cfg_we && cfg_be[0] &&
      cfg_addr == 8'h8C && is_upstream && !ovr_valid ##1
      !ovr_valid && !cfg_req |=> relaxed_order_off == $past(cfg_wdata[6], 2))
      else $error("ordering control not written");
endmodule // sptr_regs_asserts

bind sptr_regs sptr_regs_asserts i_chk (.*);
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sptr_map.svh"
// ============================================================
// Self-checking bench for the tuning register bank
module testbench;
   logic clk = 1'b0, resetn = 1'b0, is_upstream = 1'b1, six_port_mode = 1'b1;
   logic clock_buffer_powerdown_strap = 1'b1, cfg_req = 1'b0, cfg_we = 1'b0;
   logic ovr_valid = 1'b0, ovr_from_rom = 1'b0;
   logic [7:0] cfg_addr = '0, ovr_addr = '0;
   logic [3:0] cfg_be = '0;
   logic [31:0] cfg_wdata = '0, ovr_data = '0, r;
   logic [31:0] up_transaction_layer_tuning = '0;
   logic [31:0] up_phy_lane_and_delta_params = '0;
   logic [31:0] up_phy_tx_margin_params = '0;
   logic [31:0] up_operation_mode_and_clock_buffers = '0;
   logic cfg_ack, relaxed_order_off, port_disable, reset_select;
   logic retrain_disable, refclk_master_off;
   logic [31:0] cfg_rdata;
   logic [1:0] rate_change_attempt_count;
   logic [7:0] phy_misc_byte;
   logic [6:0] lane_mode, reference_clock_out_pairs;
   logic [16:0] phy_delta;
   logic [15:0] tx_margin;
   logic [8:0] op_mode_straps;
   logic [31:0] exp_q[$];
   logic [31:0] defm[4] = '{`SPTR_DEF_TL, `SPTR_DEF_PHY3, `SPTR_DEF_PHY4,
      `SPTR_DEF_OPMODE};
   logic [31:0] cur[4] = '{32'h0079_1894, 32'h0000_8000, 32'h0000_116B,
      32'h00FF_00A2};
   int fail_count = 0, num_checks = 0;

   sptr_regs i_dut (.*);

   always #50 clk = ~clk;

   // ============================================================
   // Helpers
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task wrap_up;
      if (fail_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Every access acks, so every access notes its expected read data
   task acc(input logic we, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [31:0] e);
      @(negedge clk);
      cfg_req = 1'b1;
      cfg_we = we;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      exp_q.push_back(e);
      @(negedge clk);
      cfg_req = 1'b0;
   endtask

   task ld(input logic rom, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      ovr_valid = 1'b1;
      ovr_from_rom = rom;
      ovr_addr = a;
      ovr_data = d;
      @(negedge clk);
      ovr_valid = 1'b0;
   endtask

   // Sideband may not touch the ordering bit; low mode bits never load
   function logic [31:0] ldm(input int i, input logic rom);
      return i == 3 ? 32'h0FFF_0000 : (i == 0 && !rom) ?
         defm[0] & ~32'h40 : defm[i];
   endfunction

   // ============================================================
   // Read data monitor, oldest note first
   always @(negedge clk) begin
      if (cfg_ack === 1'b1) begin
         chk(cfg_rdata, exp_q.pop_front());
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      chk(32'h0, 32'h1);
      wrap_up();
   end

   // ============================================================
   // Main sequence
   initial begin
      void'($urandom(32'hA2B0));
      cyc(16);
      resetn = 1'b1;
      for (int i = 0; i < 4; i++) acc(0, 8'h8C + 8'(i * 4), 0, 0, cur[i]);
      cyc(2);
      chk({phy_misc_byte, rate_change_attempt_count, port_disable, reset_select, retrain_disable}, {8'h79, 2'b00, 1'b0, 1'b1, 1'b1});
      chk({tx_margin, lane_mode, refclk_master_off, reference_clock_out_pairs}, {16'h116B, 7'h0, 1'b1, 7'h7F});
      chk({op_mode_straps, phy_delta}, {9'h0A2, 17'h1});
      acc(0, 8'h9C, 0, 0, 0);
      acc(1, 8'h8C, 4'hE, '1, 0);
      acc(1, 8'h98, 4'hF, '1, 0);
      acc(1, 8'h8C, 4'h1, '1, 0);
      cur[0] = cur[0] | 32'h60;
      acc(0, 8'h8C, 0, 0, cur[0]);
      acc(0, 8'h98, 0, 0, cur[3]);
      chk(relaxed_order_off, 1);
      // Random loads from both sources into every register
      for (int i = 0; i < 4; i++) begin
         for (int s = 0; s < 2; s++) begin
            r = $urandom;
            ld(s[0], 8'h8C + 8'(i * 4), r);
            cur[i] = (r & ldm(i, s[0])) | (cur[i] & ~ldm(i, s[0]));
            acc(0, 8'h8C + 8'(i * 4), 0, 0, cur[i]);
         end
      end
      cyc(2);
      chk({phy_misc_byte, port_disable, relaxed_order_off}, {cur[0][23:16], cur[0][10], cur[0][6]});
      chk({tx_margin, lane_mode, phy_delta}, {cur[2][15:0], cur[1][6:0], cur[1][31:15]});
      chk({refclk_master_off, reference_clock_out_pairs, op_mode_straps}, {cur[3][23:16], 9'h0A2});
      // Every attempt count, with port, reset-select and retrain bits
      for (int k = 0; k < 4; k++) begin
         ld(1, 8'h8C, {15'h0, k[0], 4'h0, k[1], k[0], k[1], k[0], 8'h0});
         cyc(2);
         chk({retrain_disable, reset_select, port_disable, rate_change_attempt_count}, {k[0], k[1], k[0], k[1], k[0]});
      end
      // Smaller package, strap low
      resetn = 1'b0;
      six_port_mode = 1'b0;
      clock_buffer_powerdown_strap = 1'b0;
      cyc(16);
      resetn = 1'b1;
      acc(0, 8'h98, 0, 0, 32'h005F_00A2);
      acc(0, 8'h8C, 0, 0, 32'h0079_1894);
      chk(refclk_master_off, 0);
      // Downstream port follows the upstream copies
      resetn = 1'b0;
      is_upstream = 1'b0;
      up_transaction_layer_tuning = $urandom;
      up_phy_lane_and_delta_params = $urandom;
      up_phy_tx_margin_params = $urandom;
      up_operation_mode_and_clock_buffers = $urandom;
      cyc(16);
      resetn = 1'b1;
      acc(0, 8'h8C, 0, 0, 32'h0079_0010 | (up_transaction_layer_tuning & `SPTR_UP_TL));
      acc(0, 8'h94, 0, 0, up_phy_tx_margin_params & 32'h0000_FFFF);
      acc(0, 8'h98, 0, 0, (up_operation_mode_and_clock_buffers & 32'h00FF_0000) | 32'h00A2);
      r = $urandom;
      ld(0, 8'h90, r);
      acc(0, 8'h90, 0, 0, (r & 32'h7F) | (up_phy_lane_and_delta_params & 32'hFFFF_8000));
      chk({reset_select, refclk_master_off, reference_clock_out_pairs}, {1'b0, up_operation_mode_and_clock_buffers[23:16]});
      chk({phy_delta, tx_margin}, {up_phy_lane_and_delta_params[31:15], up_phy_tx_margin_params[15:0]});
      cyc(3);
      chk(exp_q.size(), 0);
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
